// [pwmc_pkg.sv]
package pwmc_pkg;
  localparam int PWMC_NCH = 6;
  localparam int PWMC_NPAIR = 3;
  localparam logic [7:0] PWMC_RST_BYTE = 8'h00;
  localparam logic [15:0] PWMC_RST_WORD = 16'h0000;
  localparam logic [5:0] PWMC_RST_CH = 6'h00;
  localparam logic [2:0] PWMC_RST_PAIR = 3'h0;
  localparam logic PWMC_DIR_UP = 1'b0;
  localparam int PWMC_SYNC_STAGES = 2;
endpackage

// [pwmc_chan.sv]
// One counter engine; 8-bit use keeps the top byte of its operands at zero.
module pwmc_chan (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic enable,
  input wire logic center_align,
  input wire logic polarity,
  input wire logic cnt_write,
  input wire logic [15:0] duty_buf,
  input wire logic [15:0] period_buf,
  output logic wave,
  output logic [15:0] count
);
  import pwmc_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic down;
    logic ff;
    logic [15:0] duty;
    logic [15:0] period;
  } pwmc_chan_s;

  pwmc_chan_s st;
  pwmc_chan_s next_st;

  always_comb
  begin
    next_st = st;
    if (cnt_write)
    begin
      next_st.cnt = PWMC_RST_WORD; // [R6]
      next_st.down = PWMC_DIR_UP;
      next_st.duty = duty_buf;
      next_st.period = period_buf;
      next_st.ff = polarity;
    end
    else if (st.period == PWMC_RST_WORD)
    begin
      next_st.cnt = PWMC_RST_WORD; // [R10]
      next_st.down = PWMC_DIR_UP;
      next_st.duty = duty_buf;
      next_st.period = period_buf;
    end
    else if (enable && tick) // [R12]
    begin
      if (!center_align) // [R17]
      begin
        if (st.cnt + 16'h0001 >= st.period)
        begin
          next_st.cnt = PWMC_RST_WORD;
          next_st.ff = polarity;
          next_st.duty = duty_buf;
          next_st.period = period_buf;
        end
        else
        begin
          next_st.cnt = st.cnt + 16'h0001;
          if (st.cnt + 16'h0001 == st.duty)
          begin
            next_st.ff = ~polarity;
          end
        end
      end
      else if (!st.down)
      begin
        next_st.cnt = st.cnt + 16'h0001;
        if (st.cnt + 16'h0001 >= st.period)
        begin
          next_st.down = 1'b1;
        end
        if (st.cnt + 16'h0001 == st.duty)
        begin
          next_st.ff = ~st.ff;
        end
      end
      else
      begin
        next_st.cnt = st.cnt - 16'h0001;
        if (st.cnt - 16'h0001 == st.duty)
        begin
          next_st.ff = ~st.ff;
        end
        if (st.cnt == 16'h0001)
        begin
          next_st.down = PWMC_DIR_UP;
          next_st.ff = polarity;
          next_st.duty = duty_buf;
          next_st.period = period_buf;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st <= '0; // [R11]
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    if (st.period == PWMC_RST_WORD)
    begin
      wave = polarity; // [R10]
    end
    else if (st.duty == PWMC_RST_WORD)
    begin
      wave = ~polarity; // [R9]
    end
    else if (st.duty >= st.period)
    begin
      wave = polarity; // [R9]
    end
    else
    begin
      wave = st.ff;
    end
  end

  assign count = st.cnt;
endmodule // pwmc_chan

// [pwmc_top.sv]
// Functional notes
// [R1] Joined pair clocks from low-order channel select.
// [R2] Pairs map to channels five, three, one.
// [R3] Joined waveform drives low-order channel pin.
// [R4] Low-order polarity bit governs joined output.
// [R5] Only low-order enable acts; high pin off.
// [R6] Any counter byte write clears whole counter.
// [R7] Software reads joined counter in one access.
// [R8] Low-order align bit selects joined alignment.
// [R9] Zero duty or duty at period forces level.
// [R10] Zero period holds counter, output follows polarity.
// [R11] Counters start counting upward after reset.
// [R12] After reset channels disabled, counters still.
// [R13] One shutdown interrupt, gated by its enable.
// [R14] Flag sets on pin change or enabling; enabling sets it only while the synchronised pin is at shutdown_active_level.
// [R15] Even channel supplies high-order bytes.
// [R16] Join bits change only with pair disabled.
// [R17] Joined compare uses full sixteen-bit values.
module pwmc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] clock_ticks_a,
  input wire logic [5:0] clock_ticks_b,
  input wire logic [5:0] channel_clock_select,
  input wire logic [5:0] channel_enable_bit,
  input wire logic [5:0] channel_polarity_bit,
  input wire logic [5:0] channel_center_align,
  input wire logic [2:0] pair_join_control,
  input wire logic [47:0] channel_duty_value,
  input wire logic [47:0] channel_period_value,
  input wire logic [5:0] channel_counter_write,
  input wire logic shutdown_irq_enable,
  input wire logic shutdown_irq_flag_clear,
  input wire logic ch5_shutdown_input_enable,
  input wire logic shutdown_function_enable,
  input wire logic shutdown_active_level,
  input wire logic channel5_pin_in,
  output logic [5:0] channel_pin,
  output logic [47:0] channel_counter,
  output logic shutdown_irq_flag,
  output logic shutdown_irq
);
  import pwmc_pkg::*;

  typedef struct packed {
    logic [5:0] pins;
    logic [47:0] counts;
    logic sync1;
    logic sync2;
    logic pin_prev;
    logic func_prev;
    logic flag;
    logic irq;
  } pwmc_top_s;

  pwmc_top_s st;
  pwmc_top_s next_st;
  logic [5:0] tick;
  logic [5:0] en;
  logic [5:0] ca;
  logic [5:0] pol;
  logic [5:0] cwr;
  logic [95:0] duty_w;
  logic [95:0] per_w;
  logic [5:0] wave;
  logic [95:0] cnt_w;
  logic pin_moved;
  logic func_armed;
  logic flag_set;
  logic [5:0] pin_next;
  logic [47:0] cnt_view;

  // Selects channel i's tick from its clock select.
  function automatic logic sel_tick(input int i);
    return channel_clock_select[i] ? clock_ticks_b[i] : clock_ticks_a[i];
  endfunction

  // Builds a joined word with the even channel's byte on top.
  function automatic logic [15:0] join_word(input logic [7:0] hi_byte, input logic [7:0] lo_byte);
    return {hi_byte, lo_byte};
  endfunction

  // Widens one channel's byte for a stand-alone 8-bit engine.
  function automatic logic [15:0] lone_word(input logic [7:0] one_byte);
    return {PWMC_RST_BYTE, one_byte};
  endfunction

  // Shows the waveform of an enabled channel and its idle level otherwise.
  function automatic logic pin_level(input logic on, input logic w, input logic idle);
    return on ? w : idle;
  endfunction

  always_comb
  begin
    for (int p = 0; p < PWMC_NPAIR; p++)
    begin
      if (pair_join_control[p]) // [R2]
      begin
        tick[2*p+1] = sel_tick(2*p+1); // [R1]
        tick[2*p] = 1'b0;
        en[2*p+1] = channel_enable_bit[2*p+1]; // [R5]
        en[2*p] = 1'b0;
        ca[2*p+1] = channel_center_align[2*p+1]; // [R8]
        ca[2*p] = 1'b0;
        pol[2*p+1] = channel_polarity_bit[2*p+1]; // [R4]
        pol[2*p] = channel_polarity_bit[2*p];
        cwr[2*p+1] = channel_counter_write[2*p+1] | channel_counter_write[2*p]; // [R6]
        cwr[2*p] = 1'b0;
        duty_w[32*p+16 +: 16] = join_word(channel_duty_value[16*p +: 8],
                                          channel_duty_value[16*p+8 +: 8]); // [R15]
        per_w[32*p+16 +: 16] = join_word(channel_period_value[16*p +: 8],
                                         channel_period_value[16*p+8 +: 8]); // [R17]
        duty_w[32*p +: 16] = PWMC_RST_WORD;
        per_w[32*p +: 16] = PWMC_RST_WORD;
      end
      else
      begin
        for (int k = 0; k < 2; k++)
        begin
          tick[2*p+k] = sel_tick(2*p+k);
          en[2*p+k] = channel_enable_bit[2*p+k];
          ca[2*p+k] = channel_center_align[2*p+k];
          pol[2*p+k] = channel_polarity_bit[2*p+k];
          cwr[2*p+k] = channel_counter_write[2*p+k];
          duty_w[32*p+16*k +: 16] = lone_word(channel_duty_value[16*p+8*k +: 8]);
          per_w[32*p+16*k +: 16] = lone_word(channel_period_value[16*p+8*k +: 8]);
        end
      end
    end
  end

  for (genvar c = 0; c < PWMC_NCH; c++)
  begin : g_ch
    pwmc_chan u_chan (
      .clk(clk),
      .nrst(nrst),
      .tick(tick[c]),
      .enable(en[c]),
      .center_align(ca[c]),
      .polarity(pol[c]),
      .cnt_write(cwr[c]),
      .duty_buf(duty_w[16*c +: 16]),
      .period_buf(per_w[16*c +: 16]),
      .wave(wave[c]),
      .count(cnt_w[16*c +: 16])
    );
  end

  // Maps engine waveforms and counts onto the channel pins and counter bytes.
  always_comb
  begin
    pin_next = st.pins;
    cnt_view = st.counts;
    for (int p = 0; p < PWMC_NPAIR; p++)
    begin
      if (pair_join_control[p])
      begin
        pin_next[2*p+1] = pin_level(en[2*p+1], wave[2*p+1], pol[2*p+1]); // [R3]
        pin_next[2*p] = 1'b0; // [R5]
        cnt_view[16*p+8 +: 8] = cnt_w[32*p+16 +: 8];
        cnt_view[16*p +: 8] = cnt_w[32*p+24 +: 8]; // [R15]
      end
      else
      begin
        for (int k = 0; k < 2; k++)
        begin
          pin_next[2*p+k] = pin_level(en[2*p+k], wave[2*p+k], pol[2*p+k]);
          cnt_view[16*p+8*k +: 8] = cnt_w[32*p+16*k +: 8];
        end
      end
    end
  end

  // Detects the two shutdown events on the synchronised pin level.
  always_comb
  begin
    pin_moved = ch5_shutdown_input_enable && (st.sync2 != st.pin_prev);
    func_armed = shutdown_function_enable && !st.func_prev;
    flag_set = pin_moved || (func_armed && (st.sync2 == shutdown_active_level));
  end

  // A shutdown event in the same cycle as a clear keeps the flag set.
  always_comb
  begin
    next_st = st;
    next_st.sync1 = channel5_pin_in;
    next_st.sync2 = st.sync1;
    next_st.pin_prev = st.sync2;
    next_st.func_prev = shutdown_function_enable;
    next_st.pins = pin_next;
    next_st.counts = cnt_view;
    if (shutdown_irq_flag_clear)
    begin
      next_st.flag = 1'b0;
    end
    if (flag_set)
    begin
      next_st.flag = 1'b1; // [R14]
    end
    next_st.irq = next_st.flag & shutdown_irq_enable; // [R13]
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st <= '0; // [R12]
    end
    else
    begin
      st <= next_st;
    end
  end

  assign channel_pin = st.pins;
  assign channel_counter = st.counts;
  assign shutdown_irq_flag = st.flag;
  assign shutdown_irq = st.irq;
endmodule // pwmc_top

// [pwmc_sva.sv]
module pwmc_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [5:0] channel_polarity_bit,
  input wire logic [2:0] pair_join_control,
  input wire logic [47:0] channel_period_value,
  input wire logic [5:0] channel_enable_bit,
  input wire logic [5:0] channel_counter_write,
  input wire logic shutdown_irq_enable,
  input wire logic shutdown_irq_flag_clear,
  input wire logic ch5_shutdown_input_enable,
  input wire logic shutdown_function_enable,
  input wire logic channel5_pin_in,
  input wire logic [5:0] channel_pin,
  input wire logic [47:0] channel_counter,
  input wire logic shutdown_irq_flag,
  input wire logic shutdown_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_hi_off;
    pair_join_control[1] && $past(pair_join_control[1], 2) |-> !channel_pin[2];
  endproperty
  property p_clr;
    pair_join_control[1] && channel_counter_write[2] |-> ##[1:2] channel_counter[31:16] == 16'h0000;
  endproperty
  property p_still;
    (channel_enable_bit == 6'h00 && channel_counter_write == 6'h00
      && $stable(channel_period_value))[*3] |=> $stable(channel_counter);
  endproperty
  property p_per0;
    (channel_period_value[7:0] == 8'h00 && !pair_join_control[0]
      && $stable(channel_polarity_bit[0]))[*4]
      |-> channel_counter[7:0] == 8'h00 && channel_pin[0] == channel_polarity_bit[0];
  endproperty
  property p_irq;
    shutdown_irq == (shutdown_irq_flag && $past(shutdown_irq_enable));
  endproperty
  property p_sticky;
    shutdown_irq_flag && !shutdown_irq_flag_clear |=> shutdown_irq_flag;
  endproperty
  property p_set;
    $changed(channel5_pin_in) && ch5_shutdown_input_enable && !shutdown_irq_flag_clear
      |-> ##[1:4] shutdown_irq_flag;
  endproperty
  property p_clear;
    ($stable(channel5_pin_in) && $stable(shutdown_function_enable))[*4]
      ##0 shutdown_irq_flag_clear |=> !shutdown_irq_flag;
  endproperty
  a_hi_off: assert property (p_hi_off) else $error("high pin driven");
  a_clr: assert property (p_clr) else $error("counter not cleared");
  a_still: assert property (p_still) else $error("counter moved");
  a_per0: assert property (p_per0) else $error("zero period wrong");
  a_irq: assert property (p_irq) else $error("irq gate wrong");
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  a_set: assert property (p_set) else $error("flag not set");
  a_clear: assert property (p_clear) else $error("flag not cleared");
  c_clr: cover property (pair_join_control[1] && channel_counter_write[2]);
  c_flag: cover property ($rose(shutdown_irq_flag));
  c_irq: cover property ($rose(shutdown_irq));
endmodule // pwmc_sva
bind pwmc_top pwmc_sva pwmc_sva_inst (.clk, .nrst, .channel_polarity_bit, .pair_join_control,
  .channel_period_value, .channel_enable_bit, .channel_counter_write, .shutdown_irq_enable,
  .shutdown_irq_flag_clear, .ch5_shutdown_input_enable, .shutdown_function_enable,
  .channel5_pin_in, .channel_pin, .channel_counter, .shutdown_irq_flag, .shutdown_irq);

// [pwmc_top_tb.sv]
module pwmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, ie = 0, fc = 0, s5e = 0, sfe = 0, p5 = 0, al = 1;
  logic [5:0] ta = 0, tb = 0, sel = 0, en = 0, pol = 0, ca = 0, cw = 0;
  logic [2:0] jn = 0;
  logic [47:0] dty = 0, per = 0;
  logic [5:0] pin;
  logic [47:0] cnt;
  logic flag, irq;
  logic [23:0] cases [8] = '{24'h00_0410, 24'h00_0408, 24'h05_0418, 24'h05_0400,
    24'h03_0018, 24'h03_0000, 24'h01_0406, 24'h04_0418};
  int failures = 0, compares = 0, cyc = 0, hi;
  pwmc_top pwmc_top_inst (.clk, .nrst, .clock_ticks_a(ta), .clock_ticks_b(tb),
    .channel_clock_select(sel), .channel_enable_bit(en), .channel_polarity_bit(pol),
    .channel_center_align(ca), .pair_join_control(jn), .channel_duty_value(dty),
    .channel_period_value(per), .channel_counter_write(cw), .shutdown_irq_enable(ie),
    .shutdown_irq_flag_clear(fc), .ch5_shutdown_input_enable(s5e),
    .shutdown_function_enable(sfe), .shutdown_active_level(al), .channel5_pin_in(p5),
    .channel_pin(pin), .channel_counter(cnt), .shutdown_irq_flag(flag), .shutdown_irq(irq));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic count_hi(input int ch, input int n);
    hi = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1 hi += (pin[ch] === 1'b1);
    end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      wrap_up();
    end
  end
  initial
  begin
    wait_n(6);
    nrst <= 1;
    wait_n(5);
    chk({8'h00, pin, flag, irq}, 16'h0000);
    chk(cnt[15:0] | cnt[31:16] | cnt[47:32], 16'h0000);
    @(posedge clk);
    {jn, tb, sel, pol, ca} <= {3'h2, 6'h3f, 6'h08, 6'h08, 6'h04};
    {dty, per} <= {48'h0000_0201_0000, 48'h0000_0401_0000};
    @(posedge clk);
    {cw, en} <= {6'h04, 6'h08};
    @(posedge clk);
    cw <= 6'h00;
    wait_n(5);
    count_hi(3, 260);
    chk(hi[15:0], 16'h0102);
    @(posedge clk);
    {en, cw} <= {6'h00, 6'h08};
    @(posedge clk);
    cw <= 6'h00;
    wait_n(4);
    chk(cnt[31:16], 16'h0000);
    {ta, en} <= {6'h3f, 6'h01};
    foreach (cases[i])
    begin
      @(posedge clk);
      {dty[7:0], per[7:0], pol[0], cw} <= {cases[i][23:8], cases[i][4], 6'h01};
      @(posedge clk);
      cw <= 6'h00;
      wait_n(5);
      count_hi(0, 8);
      chk(hi[15:0], {12'h000, cases[i][3:0]});
    end
    @(posedge clk);
    s5e <= 1;
    wait_n(4);
    p5 <= 1;
    wait_n(6);
    chk({14'h0000, flag, irq}, 16'h0002);
    ie <= 1;
    wait_n(3);
    chk({14'h0000, flag, irq}, 16'h0003);
    fc <= 1;
    @(posedge clk);
    fc <= 0;
    wait_n(3);
    chk({14'h0000, flag, irq}, 16'h0000);
    sfe <= 1;
    wait_n(6);
    chk({15'h0000, flag}, 16'h0001);
    {s5e, sfe} <= 2'b00;
    @(posedge clk);
    fc <= 1;
    @(posedge clk);
    fc <= 0;
    wait_n(3);
    chk({15'h0000, flag}, 16'h0000);
    {al, p5} <= 2'b00;
    wait_n(5);
    sfe <= 1;
    wait_n(6);
    chk({15'h0000, flag}, 16'h0001);
    wrap_up();
  end
endmodule // pwmc_top_tb
